/* rtl/ums_pkg.sv */
// Constants, field positions and carrier types of the modem and line status block
package ums_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [2:0] UMS_OFF_DATA = 3'h0;
   localparam logic [2:0] UMS_OFF_IER  = 3'h1;
   localparam logic [2:0] UMS_OFF_LCR  = 3'h3;
   localparam logic [2:0] UMS_OFF_MCR  = 3'h4;
   localparam logic [2:0] UMS_OFF_LSR  = 3'h5;
   localparam logic [2:0] UMS_OFF_MSR  = 3'h6;
   localparam logic [2:0] UMS_OFF_EFR  = 3'h7;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] UMS_MCR_RST  = 8'h00;
   localparam logic [7:0] UMS_LCR_RST  = 8'h00;
   localparam logic [7:0] UMS_IER_RST  = 8'h00;
   localparam logic [7:0] UMS_EFR_RST  = 8'h00;
   localparam logic [7:0] UMS_TXD_RST  = 8'h00;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int UMS_MCR_DTR  = 0;
   localparam int UMS_MCR_RTS  = 1;
   localparam int UMS_MCR_FSEL = 2;
   localparam int UMS_MCR_IMM  = 3;
   localparam int UMS_MCR_LOOP = 4;
   localparam int UMS_IER_LS   = 2;
   localparam int UMS_IER_MS   = 3;
   localparam int UMS_EFR_AUTO = 6;
   localparam int UMS_TXD_DIS  = 3;
   localparam int UMS_LCR_STB  = 2;
   localparam int UMS_LCR_PEN  = 3;
   localparam int UMS_LCR_EPS  = 4;
   localparam int UMS_LCR_STK  = 5;
   localparam int UMS_FRAME_W  = 12;
   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } ums_rx_entry_t;
   typedef struct packed {
      logic cd;
      logic ri;
      logic dsr;
      logic cts;
   } ums_modem_t;
endpackage : ums_pkg

/* rtl/ums_core.sv */
// One UART channel: modem control, send-immediate, line status and modem status
// What this block does
// - Immediate byte goes out before FIFO bytes, after the current character.
// - Arm bit clears itself once used; byte uses current parity and stop setting.
// - Flow-control characters go first; immediate send only while transmitter enabled.
// - In loopback arm bit feeds carrier status, flow-select bit feeds ring status.
// - Flow-select picks RTS/CTS at zero, DTR/DSR at one, only under auto flow.
// - Outside loopback, control bits 1 and 0 drive RTS and DTR pins low when set; reset zero.
// - Line interrupt when enabled and any stored character carries an error or overrun is set.
// - Error summary is one while an erroneous character remains stored.
// - Transmitter-empty is one only when FIFO and shift register are empty.
// - Transmit FIFO empty sets as last byte leaves, clears when one is loaded.
// - Break sets flag, stores one break character, holds until line returns high.
// - Framing error flag belongs to the character at the top of the FIFO.
// - Parity error flag belongs to the character at the top of the FIFO.
// - Character completing into a full FIFO sets overrun and is not stored.
// - Data-ready is one while any received character is stored.
// - Status bits 7 and 6 show inverted CD and RI, or control bits 3 and 2.
// - Status bits 5 and 4 show inverted DSR and CTS, or DTR and RTS bits.
// - Under auto flow, a high selected input halts FIFO and immediate bytes after current character.
// - CD, DSR and CTS deltas set on change; modem interrupt when enabled.
// - Outside loopback, ring delta sets only when the RI pin rises; in loopback, when the flow-select bit clears.
// - Control bit 4 selects local loopback of the modem lines.
`timescale 1ns/1ps
`default_nettype none
module ums_core
   import ums_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_bit_tick,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [2:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output var  logic [7:0] o_reg_rdata,
   input  wire logic       i_rx,
   output var  logic       o_tx,
   output var  logic       o_rts_n,
   output var  logic       o_dtr_n,
   input  wire logic       i_cts_n,
   input  wire logic       i_dsr_n,
   input  wire logic       i_cd_n,
   input  wire logic       i_ri_n,
   input  wire logic       i_xchar_valid,
   input  wire logic [7:0] i_xchar,
   output var  logic       o_xchar_taken,
   output var  logic       o_line_irq,
   output var  logic       o_modem_irq
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   // ****************************************
   // Framing helpers
   // ****************************************
   function automatic logic ums_par(input logic [7:0] d, input logic [7:0] lcr);
      logic p;
      p = lcr[UMS_LCR_EPS] ? ^d : ~^d;
      if (lcr[UMS_LCR_STK]) begin
         p = ~lcr[UMS_LCR_EPS];
      end
      return p;
   endfunction : ums_par

   function automatic logic [15:0] ums_frame(input logic [7:0] d, input logic [7:0] lcr);
      logic [11:0] f;
      logic [7:0]  dm;
      logic [3:0]  n;
      logic [3:0]  len;
      n  = 4'h5 + {2'h0, lcr[1:0]};
      f  = '1;
      dm = 8'h00;
      f[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(n)) begin
            dm[i]  = d[i];
            f[i+1] = d[i];
         end
      end
      if (lcr[UMS_LCR_PEN]) begin
         f[n+4'h1] = ums_par(dm, lcr);
      end
      len = 4'h1 + n + {3'h0, lcr[UMS_LCR_PEN]} + (lcr[UMS_LCR_STB] ? 4'h2 : 4'h1);
      return {len, f};
   endfunction : ums_frame

   // ****************************************
   // Register access
   // ****************************************
   logic [7:0] mcr_q, lcr_q, ier_q, efr_q, txd_q;
   logic       wr_data, rd_data, rd_lsr, rd_msr, imm_take, loop;
   assign wr_data = i_reg_wr && (i_reg_addr == UMS_OFF_DATA);
   assign rd_data = i_reg_rd && (i_reg_addr == UMS_OFF_DATA);
   assign rd_lsr  = i_reg_rd && (i_reg_addr == UMS_OFF_LSR);
   assign rd_msr  = i_reg_rd && (i_reg_addr == UMS_OFF_MSR);
   assign loop    = mcr_q[UMS_MCR_LOOP];
   assign imm_take = wr_data && mcr_q[UMS_MCR_IMM] && !loop && !txd_q[UMS_TXD_DIS];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mcr_q <= UMS_MCR_RST;
      end else if (i_reg_wr && i_reg_addr == UMS_OFF_MCR) begin
         mcr_q <= i_reg_wdata;
      end else if (imm_take) begin
         mcr_q[UMS_MCR_IMM] <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lcr_q <= UMS_LCR_RST;
         ier_q <= UMS_IER_RST;
         efr_q <= UMS_EFR_RST;
         txd_q <= UMS_TXD_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == UMS_OFF_LCR) lcr_q <= i_reg_wdata;
         if (i_reg_addr == UMS_OFF_IER) ier_q <= i_reg_wdata;
         if (i_reg_addr == UMS_OFF_EFR) efr_q <= i_reg_wdata;
         // Status offset writes the disable controls
         if (i_reg_addr == UMS_OFF_MSR) txd_q <= i_reg_wdata;
      end
   end

   // ****************************************
   // Transmit FIFO and immediate byte
   // ****************************************
   logic [7:0]  tx_mem [DEPTH];
   logic [AW-1:0] tx_wp_q, tx_rp_q;
   logic [AW:0] tx_cnt_q;
   logic        tx_push, tx_pop, imm_vld_q;
   logic [7:0]  imm_q;
   assign tx_push = wr_data && !imm_take && (tx_cnt_q != FULL);

   always_ff @(posedge i_clk) begin
      if (tx_push) tx_mem[tx_wp_q] <= i_reg_wdata;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_cnt_q <= '0;
      end else begin
         if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
         if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
         tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
   end

   // ****************************************
   // Transmit engine
   // ****************************************
   logic        tx_busy_q, tx_bit_q, take_x, take_i, flow_halt, tx_done;
   logic [11:0] tx_sr_q;
   logic [3:0]  tx_left_q;
   logic [15:0] frm;
   assign flow_halt = efr_q[UMS_EFR_AUTO] && (mcr_q[UMS_MCR_FSEL] ? i_dsr_n : i_cts_n);
   assign tx_done   = !tx_busy_q || (tx_left_q == 4'h0);
   assign take_x = i_bit_tick && tx_done && i_xchar_valid;
   assign take_i = i_bit_tick && tx_done && !take_x && imm_vld_q && !flow_halt
                   && !txd_q[UMS_TXD_DIS];
   assign tx_pop = i_bit_tick && tx_done && !take_x && !take_i && !flow_halt
                   && !txd_q[UMS_TXD_DIS] && (tx_cnt_q != '0);
   assign frm = ums_frame(take_x ? i_xchar : (take_i ? imm_q : tx_mem[tx_rp_q]), lcr_q);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         imm_vld_q <= 1'b0;
         imm_q     <= 8'h00;
      end else if (imm_take) begin
         imm_vld_q <= 1'b1;
         imm_q     <= i_reg_wdata;
      end else if (take_i) begin
         imm_vld_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_busy_q <= 1'b0;
         tx_bit_q  <= 1'b1;
         tx_sr_q   <= '1;
         tx_left_q <= 4'h0;
      end else if (i_bit_tick) begin
         if (take_x || take_i || tx_pop) begin
            tx_busy_q <= 1'b1;
            tx_bit_q  <= frm[0];
            tx_sr_q   <= {1'b1, frm[11:1]};
            tx_left_q <= frm[15:12] - 4'h1;
         end else if (tx_done) begin
            tx_busy_q <= 1'b0;
            tx_bit_q  <= 1'b1;
         end else begin
            tx_bit_q  <= tx_sr_q[0];
            tx_sr_q   <= {1'b1, tx_sr_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
         end
      end
   end

   // ****************************************
   // Receive engine
   // ****************************************
   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_DATA = 4'h2,
      RX_PAR  = 4'h4,
      RX_STOP = 4'h8
   } ums_rx_st_t;
   ums_rx_st_t    rx_st_q;
   logic [2:0]    rx_cnt_q;
   logic [7:0]    rx_sh_q;
   logic          rx_pb_q, brk_hold_q, rx_in, rx_end, rx_full, rx_push, oe_q;
   logic [3:0]    rx_n;
   ums_rx_entry_t rx_ent;
   assign rx_in   = loop ? tx_bit_q : i_rx;
   assign rx_n    = 4'h5 + {2'h0, lcr_q[1:0]};
   assign rx_end  = i_bit_tick && (rx_st_q == RX_STOP);
   assign rx_ent.data = rx_sh_q;
   assign rx_ent.fe   = !rx_in;
   assign rx_ent.pe   = lcr_q[UMS_LCR_PEN] && (rx_pb_q != ums_par(rx_sh_q, lcr_q));
   // whole frame low is a break
   assign rx_ent.brk  = (rx_sh_q == 8'h00) && !rx_in && !(lcr_q[UMS_LCR_PEN] && rx_pb_q);
   assign rx_push = rx_end && !rx_full;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_st_q    <= RX_IDLE;
         rx_cnt_q   <= 3'h0;
         rx_sh_q    <= 8'h00;
         rx_pb_q    <= 1'b0;
         brk_hold_q <= 1'b0;
      end else if (i_bit_tick) begin
         unique case (rx_st_q)
            RX_IDLE: begin
               // one break character until line idles
               if (brk_hold_q) begin
                  brk_hold_q <= !rx_in;
               end else if (!rx_in) begin
                  rx_st_q  <= RX_DATA;
                  rx_cnt_q <= 3'h0;
                  rx_sh_q  <= 8'h00;
               end
            end
            RX_DATA: begin
               rx_sh_q[rx_cnt_q] <= rx_in;
               rx_cnt_q          <= rx_cnt_q + 3'h1;
               if ({1'b0, rx_cnt_q} == rx_n - 4'h1) begin
                  rx_st_q <= lcr_q[UMS_LCR_PEN] ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               rx_pb_q <= rx_in;
               rx_st_q <= RX_STOP;
            end
            RX_STOP: begin
               rx_st_q    <= RX_IDLE;
               brk_hold_q <= rx_ent.brk;
            end
         endcase
      end
   end

   // ****************************************
   // Receive FIFO with error tally
   // ****************************************
   ums_rx_entry_t rx_mem [DEPTH];
   ums_rx_entry_t top;
   logic [AW-1:0] rx_wp_q, rx_rp_q;
   logic [AW:0]   rx_cnt_f_q, err_cnt_q;
   logic          rx_pop, rx_vld, push_err, pop_err;
   assign rx_full  = (rx_cnt_f_q == FULL);
   assign rx_vld   = (rx_cnt_f_q != '0);
   assign rx_pop   = rd_data && rx_vld;
   assign top      = rx_mem[rx_rp_q];
   assign push_err = rx_push && (rx_ent.brk || rx_ent.fe || rx_ent.pe);
   assign pop_err  = rx_pop && (top.brk || top.fe || top.pe);

   always_ff @(posedge i_clk) begin
      if (rx_push) rx_mem[rx_wp_q] <= rx_ent;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_wp_q    <= '0;
         rx_rp_q    <= '0;
         rx_cnt_f_q <= '0;
         err_cnt_q  <= '0;
      end else begin
         if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
         if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
         rx_cnt_f_q <= rx_cnt_f_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
         err_cnt_q  <= err_cnt_q + (AW+1)'(push_err) - (AW+1)'(pop_err);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_q <= 1'b0;
      end else if (rx_end && rx_full) begin
         oe_q <= 1'b1;
      end else if (rd_lsr) begin
         oe_q <= 1'b0;
      end
   end

   // ****************************************
   // Line status
   // ****************************************
   logic [7:0] line_status;
   assign line_status = {err_cnt_q != '0,
                 (tx_cnt_q == '0) && !imm_vld_q && !tx_busy_q,
                 (tx_cnt_q == '0) && !imm_vld_q,
                 (rx_vld && top.brk) || brk_hold_q,
                 rx_vld && top.fe,
                 rx_vld && top.pe,
                 oe_q,
                 rx_vld};

   // ****************************************
   // Modem status
   // ****************************************
   ums_modem_t st, st_q, dlt_q;
   always_comb begin
      // arm and flow-select bits feed carrier and ring
      if (loop) begin
         st = '{cd: mcr_q[UMS_MCR_IMM], ri: mcr_q[UMS_MCR_FSEL],
                dsr: mcr_q[UMS_MCR_DTR], cts: mcr_q[UMS_MCR_RTS]};
      end else begin
         st = '{cd: !i_cd_n, ri: !i_ri_n, dsr: !i_dsr_n, cts: !i_cts_n};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q  <= '0;
         dlt_q <= '0;
      end else begin
         st_q <= st;
         // ring delta only on pin rise, or on flow-select fall in loopback
         dlt_q.cd  <= (st.cd ^ st_q.cd) || (dlt_q.cd && !rd_msr);
         dlt_q.ri  <= (st_q.ri && !st.ri) || (dlt_q.ri && !rd_msr);
         dlt_q.dsr <= (st.dsr ^ st_q.dsr) || (dlt_q.dsr && !rd_msr);
         dlt_q.cts <= (st.cts ^ st_q.cts) || (dlt_q.cts && !rd_msr);
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            UMS_OFF_DATA: o_reg_rdata <= rx_vld ? top.data : 8'h00;
            UMS_OFF_IER:  o_reg_rdata <= ier_q;
            UMS_OFF_LCR:  o_reg_rdata <= lcr_q;
            UMS_OFF_MCR:  o_reg_rdata <= mcr_q;
            UMS_OFF_LSR:  o_reg_rdata <= line_status;
            UMS_OFF_MSR:  o_reg_rdata <= {st, dlt_q};
            UMS_OFF_EFR:  o_reg_rdata <= efr_q;
            default:      o_reg_rdata <= 8'h00;
         endcase
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

   // Loopback parks the pins idle so the far end sees no traffic
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tx          <= 1'b1;
         o_rts_n       <= 1'b1;
         o_dtr_n       <= 1'b1;
         o_xchar_taken <= 1'b0;
         o_line_irq    <= 1'b0;
         o_modem_irq   <= 1'b0;
      end else begin
         o_tx          <= loop ? 1'b1 : tx_bit_q;
         o_rts_n       <= loop ? 1'b1 : !mcr_q[UMS_MCR_RTS];
         o_dtr_n       <= loop ? 1'b1 : !mcr_q[UMS_MCR_DTR];
         o_xchar_taken <= take_x;
         o_line_irq    <= ier_q[UMS_IER_LS] && (line_status[7] || oe_q);
         o_modem_irq   <= ier_q[UMS_IER_MS] && (dlt_q != '0);
      end
   end
endmodule : ums_core
`default_nettype wire

/* verif/ums_core_properties.sv */
// Property checker for the modem and line status channel
`timescale 1ns/1ps
`default_nettype none
module ums_core_properties
   import ums_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic       i_clk,
   input wire logic       i_rst_n,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [2:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_tx,
   input wire logic       o_rts_n,
   input wire logic       o_dtr_n,
   input wire logic       i_cts_n,
   input wire logic       i_dsr_n,
   input wire logic       i_cd_n,
   input wire logic       i_ri_n,
   input wire logic       o_line_irq,
   input wire logic       o_modem_irq
);
   logic [7:0]      mcr_q;
   logic [7:0]      ier_q;
   logic            txd_q;
   logic [3:0]      pins_q;
   logic [2:0]      quiet_q;
   wire logic [3:0] pins   = {i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
   wire logic [3:0] lb     = {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]};
   wire logic       wr_mcr = i_reg_wr && i_reg_addr == UMS_OFF_MCR;
   wire logic       wr_dat = i_reg_wr && i_reg_addr == UMS_OFF_DATA;
   wire logic       rd_msr = i_reg_rd && i_reg_addr == UMS_OFF_MSR;
   // ****************************************
   // Shadow state
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mcr_q <= UMS_MCR_RST;
         ier_q <= UMS_IER_RST;
         txd_q <= 1'b0;
      end else begin
         if (wr_mcr) begin
            mcr_q <= i_reg_wdata;
         end else if (wr_dat && mcr_q[UMS_MCR_IMM] && !mcr_q[UMS_MCR_LOOP] && !txd_q) begin
            mcr_q[UMS_MCR_IMM] <= 1'b0;
         end
         if (i_reg_wr && i_reg_addr == UMS_OFF_IER) begin
            ier_q <= i_reg_wdata;
         end
         if (i_reg_wr && i_reg_addr == UMS_OFF_MSR) begin
            txd_q <= i_reg_wdata[UMS_TXD_DIS];
         end
      end
   end
   // Cycles since the last pin or control change
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins_q  <= 4'hF;
         quiet_q <= 3'h0;
      end else begin
         pins_q <= pins;
         if (wr_mcr || pins != pins_q) begin
            quiet_q <= 3'h0;
         end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
         end
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   chk_modem_pins: assert property (
      !$past(wr_mcr) && !$past(wr_mcr, 2) |->
      o_rts_n == (!mcr_q[1] || mcr_q[4]) && o_dtr_n == (!mcr_q[0] || mcr_q[4]))
      else $error("modem pins wrong");
   chk_loop_parks: assert property (
      mcr_q[4] && $past(mcr_q[4]) && $past(mcr_q[4], 2) |-> o_tx && o_rts_n && o_dtr_n)
      else $error("pins not parked");
   chk_status_pins: assert property (
      rd_msr && !mcr_q[4] && quiet_q > 3'h1 |=> o_reg_rdata[7:4] == ~$past(pins))
      else $error("status not pins");
   chk_status_loop: assert property (
      rd_msr && mcr_q[4] && quiet_q > 3'h1 |=> o_reg_rdata[7:4] == $past(lb))
      else $error("status not loop");
   chk_ctl_readback: assert property (
      i_reg_rd && i_reg_addr == UMS_OFF_MCR |=> o_reg_rdata[4:0] == $past(mcr_q[4:0]))
      else $error("control readback");
   chk_line_mask: assert property (
      !ier_q[UMS_IER_LS] && !$past(ier_q[UMS_IER_LS]) |-> !o_line_irq)
      else $error("line irq masked");
   chk_modem_mask: assert property (
      !ier_q[UMS_IER_MS] && !$past(ier_q[UMS_IER_MS]) |-> !o_modem_irq)
      else $error("modem irq masked");
   chk_delta_clear: assert property (
      rd_msr ##1 quiet_q > 3'h3 && pins == pins_q |=> !o_modem_irq)
      else $error("delta not cleared");
   cover property (rd_msr && mcr_q[4]);
   cover property (o_modem_irq ##1 !o_modem_irq);
   cover property (o_line_irq);
endmodule : ums_core_properties
bind ums_core ums_core_properties #(.DEPTH(DEPTH)) u_props (.*);
`default_nettype wire

/* verif/ums_peer.sv */
// Remote serial peer: drives receive line, decodes sent bytes
`timescale 1ns/1ps
`default_nettype none
module ums_peer (
   input  wire logic i_clk,
   input  wire logic i_tick,
   input  wire logic i_tx,
   output var  logic o_rx
);
   logic [7:0] got_q[$];
   logic [7:0] sh_q;
   int         cnt_q = 0;
   initial o_rx = 1'b1;
   // ****************************************
   // Receive side, 8N1 only
   // ****************************************
   always @(posedge i_clk) begin
      if (i_tick) begin
         if (cnt_q == 0) begin
            if (!i_tx) begin
               cnt_q <= 1;
            end
         end else if (cnt_q < 9) begin
            sh_q  <= {i_tx, sh_q[7:1]};
            cnt_q <= cnt_q + 1;
         end else begin
            got_q.push_back(sh_q);
            cnt_q <= 0;
         end
      end
   end
   // Bits LSB first, one per tick, then back to mark
   task automatic send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk iff i_tick);
         #1 o_rx = f[i];
      end
      @(posedge i_clk iff i_tick);
      #1 o_rx = 1'b1;
   endtask : send
endmodule : ums_peer
`default_nettype wire

/* verif/tb_uart_modem_line_status.sv */
// Self-checking bench for the modem and line status channel
`timescale 1ns/1ps
`default_nettype none
module tb_uart_modem_line_status;
   import ums_pkg::*;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        tick  = 1'b0;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic        rd_d  = 1'b0;
   logic        xv    = 1'b0;
   logic        rx, tx, rts_n, dtr_n, xt, lirq, mirq;
   logic [1:0]  tc    = 2'd0;
   logic [2:0]  addr  = 3'h0;
   logic [3:0]  pins  = 4'hF;
   logic [3:0]  p     = 4'hF;
   logic [7:0]  wd    = 8'h00;
   logic [7:0]  xc    = 8'h00;
   logic [7:0]  rdat, v;
   logic [7:0]  exp_q[$], msk_q[$], txe_q[$], rq[5];
   logic [31:0] seed  = 32'h0000_881C;
   int          n_fail = 0, n_checks = 0, k;
   ums_core #(.DEPTH(4)) uut (
      .i_clk(clk), .i_rst_n(rst_n), .i_bit_tick(tick), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_rx(rx), .o_tx(tx),
      .o_rts_n(rts_n), .o_dtr_n(dtr_n), .i_cts_n(pins[0]), .i_dsr_n(pins[1]),
      .i_cd_n(pins[3]), .i_ri_n(pins[2]), .i_xchar_valid(xv), .i_xchar(xc),
      .o_xchar_taken(xt), .o_line_irq(lirq), .o_modem_irq(mirq));
   ums_peer u_peer (.i_clk(clk), .i_tick(tick), .i_tx(tx), .o_rx(rx));
   // ****************************************
   // Clock, bit tick, helpers
   // ****************************************
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      #1;
      tc = tc + 2'd1;
      tick = (tc == 2'd0);
   end
   function automatic logic [7:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xorshift
   // Strobes stay up so back-to-back cycles never toggle twice
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      wr = w;
      rd = !w;
      addr = a;
      wd = d;
      @(posedge clk);
      #1;
   endtask : bus
   task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(1'b0, a, 8'h00);
   endtask : rreg
   task automatic idle(input int n);
      wr = 1'b0;
      rd = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] m, input logic [7:0] s);
      n_checks++;
      if ((s & m) !== (e & m)) begin
         n_fail++;
         $display("unexpected reg read: expected %h seen %h", e & m, s & m);
      end
   endtask : cmp_reg
   task automatic cmp_tx(input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected tx byte: expected %h seen %h", e, s);
      end
   endtask : cmp_tx
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d) begin
         cmp_reg(exp_q.pop_front(), msk_q.pop_front(), rdat);
      end
      if (u_peer.got_q.size() != 0) begin
         cmp_tx(txe_q.pop_front(), u_peer.got_q.pop_front());
      end
   end
   initial begin
      #(40000 * 20);
      n_fail++;
      print_verdict();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      idle(1);
      rreg(UMS_OFF_MCR, 8'h00);
      rreg(UMS_OFF_LSR, 8'h60);
      rreg(UMS_OFF_MSR, 8'h00);
      bus(1'b1, UMS_OFF_IER, 8'h0C);
      bus(1'b1, UMS_OFF_LCR, 8'h03);
      bus(1'b1, UMS_OFF_MCR, 8'h03);
      rreg(UMS_OFF_MCR, 8'h03);
      for (int i = 0; i < 4; i++) begin
         v = xorshift();
         bus(1'b1, UMS_OFF_MCR, {4'h1, v[3:0]});
         idle(3);
         rreg(UMS_OFF_MSR, {v[3], v[2], v[0], v[1], 4'h0}, 8'hF0);
      end
      bus(1'b1, UMS_OFF_MCR, 8'h00);
      idle(4);
      rreg(UMS_OFF_MSR, 8'h00, 8'hF0);
      for (int i = 0; i < 6; i++) begin
         v = xorshift();
         pins = v[3:0];
         idle(4);
         rreg(UMS_OFF_MSR, {~v[3:0], v[3] ^ p[3], v[2] & ~p[2], v[1:0] ^ p[1:0]},
              8'hFF);
         p = v[3:0];
      end
      pins = 4'hF;
      $display("test modem lines done");
      bus(1'b1, UMS_OFF_DATA, 8'hA1);
      txe_q.push_back(8'hA1);
      idle(8);
      bus(1'b1, UMS_OFF_DATA, 8'hB2);
      bus(1'b1, UMS_OFF_DATA, 8'hC3);
      xc = 8'h5E;
      xv = 1'b1;
      bus(1'b1, UMS_OFF_MCR, 8'h08);
      bus(1'b1, UMS_OFF_DATA, 8'hD4);
      txe_q = {txe_q, 8'h5E, 8'hD4, 8'hB2, 8'hC3};
      rreg(UMS_OFF_MCR, 8'h00);
      rreg(UMS_OFF_LSR, 8'h00, 8'h60);
      for (k = 0; k < 400 && xt !== 1'b1; k++) idle(1);
      xv = 1'b0;
      if (k == 400) n_fail++;
      idle(220);
      rreg(UMS_OFF_LSR, 8'h60, 8'h60);
      bus(1'b1, UMS_OFF_MSR, 8'h08);
      bus(1'b1, UMS_OFF_MCR, 8'h08);
      bus(1'b1, UMS_OFF_DATA, 8'h3C);
      rreg(UMS_OFF_MCR, 8'h08, 8'hFF);
      idle(100);
      rreg(UMS_OFF_LSR, 8'h00, 8'h40);
      bus(1'b1, UMS_OFF_MCR, 8'h00);
      txe_q.push_back(8'h3C);
      bus(1'b1, UMS_OFF_MSR, 8'h00);
      idle(60);
      bus(1'b1, UMS_OFF_EFR, 8'h40);
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, UMS_OFF_MCR, (s == 0) ? 8'h00 : 8'h04);
         pins = (s == 0) ? 4'b1101 : 4'b1110;
         v = xorshift();
         bus(1'b1, UMS_OFF_DATA, v);
         txe_q.push_back(v);
         idle(100);
         rreg(UMS_OFF_LSR, 8'h00, 8'h40);
         pins = 4'b1100;
         idle(60);
         rreg(UMS_OFF_LSR, 8'h40, 8'h40);
      end
      bus(1'b1, UMS_OFF_EFR, 8'h00);
      pins = 4'hF;
      idle(1);
      $display("test transmit order done");
      u_peer.send({2'b11, 8'h5A, 1'b0}, 10);
      u_peer.send({2'b10, 8'hA5, 1'b0}, 10);
      idle(8);
      rreg(UMS_OFF_LSR, 8'hE1);
      rreg(UMS_OFF_DATA, 8'h5A);
      rreg(UMS_OFF_LSR, 8'hE9);
      rreg(UMS_OFF_DATA, 8'hA5);
      rreg(UMS_OFF_LSR, 8'h60);
      bus(1'b1, UMS_OFF_LCR, 8'h0B);
      idle(1);
      u_peer.send({2'b11, 8'h01, 1'b0}, 11);
      idle(4);
      rreg(UMS_OFF_LSR, 8'hE5);
      rreg(UMS_OFF_DATA, 8'h01);
      idle(1);
      u_peer.send(11'h000, 11);
      idle(4);
      // Break character also lacks stop bit and odd parity
      rreg(UMS_OFF_LSR, 8'hFD);
      rreg(UMS_OFF_DATA, 8'h00);
      rreg(UMS_OFF_LSR, 8'h60);
      bus(1'b1, UMS_OFF_LCR, 8'h03);
      idle(1);
      for (int i = 0; i < 5; i++) begin
         rq[i] = xorshift();
         u_peer.send({2'b11, rq[i], 1'b0}, 10);
      end
      idle(4);
      rreg(UMS_OFF_LSR, 8'h63);
      for (int i = 0; i < 4; i++) rreg(UMS_OFF_DATA, rq[i]);
      rreg(UMS_OFF_LSR, 8'h60);
      rreg(UMS_OFF_DATA, 8'h00);
      idle(4);
      $display("test receive status done");
      print_verdict();
   end
endmodule : tb_uart_modem_line_status
`default_nettype wire
